/* verilog/mip_ctrl.sv */
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ns
`include "mip_defines.svh"
module mip_ctrl #(
    parameter int unsigned PWR_HOLD_CYC  = `MIP_PWR_HOLD_CYC,
    parameter int unsigned INIT_WAIT_CYC = `MIP_INIT_WAIT_CYC,
    parameter int unsigned MRD_CYC       = `MIP_MRD_CYC,
    parameter int unsigned MOD_CYC       = `MIP_MOD_CYC,
    parameter int unsigned DLLK_CYC      = `MIP_DLLK_CYC,
    parameter int unsigned ZQINIT_CYC    = `MIP_ZQINIT_CYC,
    parameter int unsigned RP_CYC        = `MIP_RP_CYC,
    parameter int unsigned ST_CYC        = `MIP_ST_CYC,
    parameter int unsigned CNT_W         = 20
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    mip_if.ctrl              mem
);
    if (PWR_HOLD_CYC < `MIP_CKE_SETUP_CYC || INIT_WAIT_CYC < 1 || MRD_CYC < 1 || MOD_CYC < 1 ||
        DLLK_CYC < 1 || ZQINIT_CYC < 1 || RP_CYC < 1 || ST_CYC < 1 ||
        PWR_HOLD_CYC >= (1 << CNT_W) || INIT_WAIT_CYC >= (1 << CNT_W) ||
        DLLK_CYC >= (1 << CNT_W) || ZQINIT_CYC >= (1 << CNT_W) || ST_CYC >= (1 << CNT_W)) begin : g_bad_cfg
        $error("mip_ctrl: count out of range for CNT_W");
    end

    // Load value of a down counter that expires after n cycles
    function automatic logic [CNT_W-1:0] ld(input int unsigned n);
        return CNT_W'(n - 1);
    endfunction : ld

    // Initialization order MR3, MR6, MR5, MR4, MR2, MR1, MR0
    function automatic logic [2:0] mr_order(input logic [2:0] idx);
        case (idx)
            3'h0:    return 3'h3;
            3'h1:    return 3'h6;
            3'h2:    return 3'h5;
            3'h3:    return 3'h4;
            3'h4:    return 3'h2;
            3'h5:    return 3'h1;
            default: return 3'h0;
        endcase
    endfunction : mr_order

    // Full register image with fields forced to safe values
    function automatic logic [13:0] mr_force(input logic [2:0] sel, input logic [13:0] val,
                                             input logic init);
        logic [13:0] v;
        v = val;
        case (sel)
            3'h0: if (init) v[`MIP_MR0_DLL_RST] = 1'b1;
            3'h1: v[`MIP_MR1_DLL_EN] = 1'b1;
            3'h3: begin
                v[`MIP_MR3_GEARDOWN] = 1'b0;
                v[`MIP_MR3_PDA]      = 1'b0;
            end
            3'h4: begin
                v[`MIP_MR4_MPSM] = 1'b0;
                v[`MIP_MR4_CAL_MSB:`MIP_MR4_CAL_LSB] = 3'h0;
            end
            3'h5: v[`MIP_MR5_PAR_MSB:`MIP_MR5_PAR_LSB] = 3'h0;
            default: v = val;
        endcase
        return v;
    endfunction : mr_force

    mip_pkg::mip_cstate_type st_q, st_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [2:0]              idx_q, idx_d;
    logic [13:0]             mr_q [7];
    logic                    op_store_q;
    logic [2:0]              upd_sel_q;
    logic                    stored_q;
    logic [31:0]             rdata_q;
    logic                    reset_n_q, ck_en_q, cke_q, cs_n_q;
    logic [3:0]              cmd_q;
    logic [2:0]              sel_q;
    logic [13:0]             addr_q;

    wire cnt_done  = (cnt_q == '0);
    wire ctrl_wr   = reg_wr_i && reg_addr_i == `MIP_REG_CTRL;
    wire stat_wr   = reg_wr_i && reg_addr_i == `MIP_REG_STATUS;
    wire is_ready  = (st_q == mip_pkg::C_READY);
    wire warm_req  = ctrl_wr && reg_wdata_i[`MIP_CTRL_WARM];
    wire store_req = ctrl_wr && reg_wdata_i[`MIP_CTRL_STORE];
    wire upd_req   = ctrl_wr && reg_wdata_i[`MIP_CTRL_UPD];
    wire [2:0] req_sel = reg_wdata_i[`MIP_CTRL_SEL_LSB +: 3];
    wire store_end = (st_q == mip_pkg::C_ST_WAIT) && cnt_done;

    always_comb begin
        st_d  = st_q;
        idx_d = idx_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        case (st_q)
            mip_pkg::C_PWR_HOLD, mip_pkg::C_RST_HOLD: begin
                if (cnt_done) begin
                    st_d  = mip_pkg::C_INIT_WAIT;
                    cnt_d = ld(INIT_WAIT_CYC);
                end
            end
            mip_pkg::C_INIT_WAIT: begin
                if (cnt_done) begin
                    st_d  = mip_pkg::C_CLK_STAB;
                    cnt_d = ld(`MIP_CLK_STAB_CYC);
                end
            end
            mip_pkg::C_CLK_STAB: begin
                if (cnt_done) st_d = mip_pkg::C_CKE_UP;
            end
            mip_pkg::C_CKE_UP: begin
                st_d  = mip_pkg::C_XPR;
                cnt_d = ld(`MIP_XPR_CYC);
            end
            mip_pkg::C_XPR: begin
                if (cnt_done) begin
                    st_d  = mip_pkg::C_MRS;
                    idx_d = 3'h0;
                end
            end
            mip_pkg::C_MRS: begin
                st_d  = mip_pkg::C_MRS_WAIT;
                cnt_d = (idx_q == 3'h6) ? ld(MOD_CYC) : ld(MRD_CYC);
            end
            mip_pkg::C_MRS_WAIT: begin
                if (cnt_done) begin
                    if (idx_q == 3'h6) begin
                        st_d = mip_pkg::C_ZQ;
                    end else begin
                        st_d  = mip_pkg::C_MRS;
                        idx_d = idx_q + 3'h1;
                    end
                end
            end
            mip_pkg::C_ZQ: begin
                st_d  = mip_pkg::C_ZQ_WAIT;
                cnt_d = ld(`MIP_MAX(DLLK_CYC, ZQINIT_CYC));
            end
            mip_pkg::C_ZQ_WAIT: begin
                if (cnt_done) st_d = mip_pkg::C_READY;
            end
            mip_pkg::C_READY: begin
                if (warm_req) begin
                    st_d  = mip_pkg::C_RST_HOLD;
                    cnt_d = ld(`MIP_RST_HOLD_CYC);
                end else if (store_req || upd_req) begin
                    st_d = mip_pkg::C_PRE;
                end
            end
            mip_pkg::C_PRE: begin
                st_d  = mip_pkg::C_PRE_WAIT;
                cnt_d = ld(RP_CYC);
            end
            mip_pkg::C_PRE_WAIT: begin
                if (cnt_done) st_d = op_store_q ? mip_pkg::C_STORE : mip_pkg::C_UPD;
            end
            mip_pkg::C_STORE: begin
                st_d  = mip_pkg::C_ST_WAIT;
                cnt_d = ld(ST_CYC);
            end
            mip_pkg::C_UPD: begin
                st_d  = mip_pkg::C_UPD_WAIT;
                cnt_d = ld(MOD_CYC);
            end
            mip_pkg::C_ST_WAIT, mip_pkg::C_UPD_WAIT: begin
                if (cnt_done) st_d = mip_pkg::C_READY;
            end
            default: st_d = mip_pkg::C_PWR_HOLD;
        endcase
    end

    // Pin values decoded from the current state
    wire        in_rst    = (st_q == mip_pkg::C_PWR_HOLD) || (st_q == mip_pkg::C_RST_HOLD);
    wire        cke_low   = in_rst || st_q == mip_pkg::C_INIT_WAIT || st_q == mip_pkg::C_CLK_STAB;
    wire        iss_init  = (st_q == mip_pkg::C_MRS);
    wire        iss_mrs   = iss_init || st_q == mip_pkg::C_UPD;
    wire        iss_zq    = (st_q == mip_pkg::C_ZQ);
    wire        iss_pre   = (st_q == mip_pkg::C_PRE);
    wire        iss_store = (st_q == mip_pkg::C_STORE);
    wire [2:0]  sel_d     = iss_init ? mr_order(idx_q) : upd_sel_q;
    wire [3:0]  cmd_d     = iss_mrs   ? `MIP_CMD_MRS :
                            iss_zq    ? `MIP_CMD_ZQ :
                            iss_pre   ? `MIP_CMD_PRE :
                            iss_store ? `MIP_CMD_STORE : `MIP_CMD_DES;
    wire [13:0] a10_word  = 14'h0001 << `MIP_A10;
    wire [13:0] addr_d    = iss_mrs ? mr_force(sel_d, mr_q[sel_d], iss_init) :
                            (iss_zq || iss_pre || iss_store) ? a10_word : 14'h0000;
    wire [31:0] stat_word = {19'h0, 5'(st_q), 6'h0, stored_q, is_ready};
    wire [3:0]  mr_off    = reg_addr_i - `MIP_REG_MR_BASE;
    wire        mr_hit    = reg_addr_i >= `MIP_REG_MR_BASE && reg_addr_i <= `MIP_REG_MR_LAST;
    wire [31:0] rd_mux    = (reg_addr_i == `MIP_REG_STATUS) ? stat_word :
                            mr_hit ? {18'h0, mr_q[mr_off[2:0]]} : 32'h0;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q       <= mip_pkg::C_PWR_HOLD;
            cnt_q      <= ld(PWR_HOLD_CYC);
            idx_q      <= 3'h0;
            op_store_q <= 1'b0;
            upd_sel_q  <= 3'h0;
            stored_q   <= 1'b0;
            rdata_q    <= 32'h0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            idx_q   <= idx_d;
            rdata_q <= reg_rd_i ? rd_mux : 32'h0;
            if (is_ready && !warm_req && (store_req || upd_req)) begin
                op_store_q <= store_req;
                upd_sel_q  <= req_sel;
            end
            // Set wins over write-one-to-clear
            stored_q <= store_end || (stored_q && !(stat_wr && reg_wdata_i[`MIP_STAT_STORED]));
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reset_n_q <= 1'b0;
            ck_en_q   <= 1'b0;
            cke_q     <= 1'b0;
            cs_n_q    <= 1'b1;
            cmd_q     <= `MIP_CMD_DES;
            sel_q     <= 3'h0;
            addr_q    <= 14'h0000;
        end else begin
            reset_n_q <= !in_rst;
            ck_en_q   <= !in_rst;
            cke_q     <= !cke_low;
            cs_n_q    <= (cmd_d == `MIP_CMD_DES);
            cmd_q     <= cmd_d;
            sel_q     <= sel_d;
            addr_q    <= addr_d;
        end
    end

    for (genvar i = 0; i < 7; i++) begin : g_mr
        always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
                mr_q[i] <= 14'h0000;
            end else if (reg_wr_i && mr_hit && mr_off[2:0] == 3'(i)) begin
                mr_q[i] <= reg_wdata_i[13:0];
            end
        end
    end

    assign mem.reset_n = reset_n_q;
    assign mem.ck_en   = ck_en_q;
    assign mem.cke     = cke_q;
    assign mem.cs_n    = cs_n_q;
    assign mem.cmd     = cmd_q;
    assign mem.bg      = {1'b0, sel_q[2]};
    assign mem.ba      = sel_q[1:0];
    assign mem.addr    = addr_q;
    assign mem.odt     = 1'b0;
    assign reg_rdata_o = rdata_q;
endmodule : mip_ctrl

/* verilog/mip_defines.svh */
`ifndef MIP_DEFINES_SVH
`define MIP_DEFINES_SVH

// Clock and conversion of least times to whole cycles
`define MIP_CLK_PERIOD_PS   4000
`define MIP_NS_TO_CYC(ns)   ((((ns) * 1000) + `MIP_CLK_PERIOD_PS - 1) / `MIP_CLK_PERIOD_PS)
`define MIP_MAX(a, b)       (((a) > (b)) ? (a) : (b))

// Times in ns and in clock cycles of the memory clock
`define MIP_T_PWR_HOLD_NS   200000
`define MIP_T_RST_HOLD_NS   100
`define MIP_T_CKE_SETUP_NS  10
`define MIP_T_INIT_WAIT_NS  500000
`define MIP_T_CLK_STAB_NS   10
`define MIP_T_CLK_STAB_TCK  5
`define MIP_T_XS_NS         10
`define MIP_T_XPR_TCK       5

`define MIP_PWR_HOLD_CYC    `MIP_NS_TO_CYC(`MIP_T_PWR_HOLD_NS)
`define MIP_RST_HOLD_CYC    `MIP_NS_TO_CYC(`MIP_T_RST_HOLD_NS)
`define MIP_CKE_SETUP_CYC   `MIP_NS_TO_CYC(`MIP_T_CKE_SETUP_NS)
`define MIP_INIT_WAIT_CYC   `MIP_NS_TO_CYC(`MIP_T_INIT_WAIT_NS)
`define MIP_CLK_STAB_CYC    `MIP_MAX(`MIP_NS_TO_CYC(`MIP_T_CLK_STAB_NS), `MIP_T_CLK_STAB_TCK)
`define MIP_XPR_CYC         `MIP_MAX(`MIP_NS_TO_CYC(`MIP_T_XS_NS), `MIP_T_XPR_TCK)
`define MIP_MRD_CYC         8
`define MIP_MOD_CYC         24
`define MIP_DLLK_CYC        1024
`define MIP_ZQINIT_CYC      1024
`define MIP_RP_CYC          8
`define MIP_ST_CYC          64

// Register indices
`define MIP_REG_CTRL        4'h0
`define MIP_REG_STATUS      4'h1
`define MIP_REG_MR_BASE     4'h2
`define MIP_REG_MR_LAST     4'h8

// Control and status fields
`define MIP_CTRL_WARM       0
`define MIP_CTRL_STORE      1
`define MIP_CTRL_UPD        2
`define MIP_CTRL_SEL_LSB    4
`define MIP_STAT_READY      0
`define MIP_STAT_STORED     1
`define MIP_STAT_STATE_LSB  8

// Command encodings {act_n, ras_n, cas_n, we_n}
`define MIP_CMD_DES         4'hf
`define MIP_CMD_MRS         4'h8
`define MIP_CMD_ZQ          4'he
`define MIP_CMD_PRE         4'ha
`define MIP_CMD_STORE       4'h9
`define MIP_A10             10

// Mode register field positions
`define MIP_MR_RCW          3'h7
`define MIP_MR1_DLL_EN      0
`define MIP_MR0_DLL_RST     8
`define MIP_MR3_GEARDOWN    3
`define MIP_MR3_PDA         4
`define MIP_MR4_MPSM        1
`define MIP_MR4_CAL_LSB     6
`define MIP_MR4_CAL_MSB     8
`define MIP_MR5_PAR_LSB     0
`define MIP_MR5_PAR_MSB     2

`endif

/* verilog/mip_pkg.sv */
package mip_pkg;

    typedef enum logic [4:0] {
        C_PWR_HOLD, C_RST_HOLD, C_INIT_WAIT, C_CLK_STAB, C_CKE_UP, C_XPR,
        C_MRS, C_MRS_WAIT, C_ZQ, C_ZQ_WAIT, C_READY,
        C_PRE, C_PRE_WAIT, C_STORE, C_ST_WAIT, C_UPD, C_UPD_WAIT
    } mip_cstate_type;

    typedef enum logic [2:0] {
        D_RESET, D_INIT, D_WAIT_CKE, D_CONFIG, D_CAL, D_READY
    } mip_dstate_type;

    typedef logic [13:0] mip_addr_type;

endpackage : mip_pkg

/* verilog/mip_if.sv */
`timescale 1ns/1ns
interface mip_if;
    logic                 reset_n;
    logic                 ck_en;
    logic                 cke;
    logic                 cs_n;
    logic [3:0]           cmd;
    logic [1:0]           bg;
    logic [1:0]           ba;
    mip_pkg::mip_addr_type addr;
    logic                 odt;

    modport ctrl (output reset_n, ck_en, cke, cs_n, cmd, bg, ba, addr, odt);
    modport dev  (input  reset_n, ck_en, cke, cs_n, cmd, bg, ba, addr, odt);
endinterface : mip_if

/* verilog/mip_device.sv */
`timescale 1ns/1ns
`include "mip_defines.svh"
module mip_device #(
    parameter int unsigned INIT_WAIT_CYC = `MIP_INIT_WAIT_CYC,
    parameter int unsigned DLLK_CYC      = `MIP_DLLK_CYC,
    parameter int unsigned ZQINIT_CYC    = `MIP_ZQINIT_CYC,
    parameter int unsigned CNT_W         = 20
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    mip_if.dev               mem,
    input  wire logic [2:0]  mr_sel_i,
    output logic      [13:0] mr_data_o,
    output logic             ready_o,
    output logic             term_hiz_o,
    output logic             store_seen_o
);
    if (INIT_WAIT_CYC < 1 || INIT_WAIT_CYC >= (1 << CNT_W) || DLLK_CYC < 1 || ZQINIT_CYC < 1 ||
        DLLK_CYC >= (1 << CNT_W) || ZQINIT_CYC >= (1 << CNT_W)) begin : g_bad_cfg
        $error("mip_device: count out of range for CNT_W");
    end

    function automatic logic [CNT_W-1:0] ld(input int unsigned n);
        return CNT_W'(n - 1);
    endfunction : ld

    mip_pkg::mip_dstate_type st_q, st_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [13:0]             mr_q [7];
    logic                    cke_seen_q;
    logic                    ready_q;
    logic                    store_q;
    logic [13:0]             mr_data_q;

    wire       cnt_done = (cnt_q == '0);
    wire       cmd_ok   = mem.cke && !mem.cs_n;
    wire [2:0] mr_sel   = {mem.bg[0], mem.ba};
    wire       cfg_st   = (st_q == mip_pkg::D_CONFIG) || (st_q == mip_pkg::D_READY);
    wire       is_mrs   = cmd_ok && mem.cmd == `MIP_CMD_MRS && cfg_st && !mem.bg[1] && mr_sel != `MIP_MR_RCW;
    wire       is_zq    = cmd_ok && mem.cmd == `MIP_CMD_ZQ && mem.addr[`MIP_A10];
    wire       is_store = cmd_ok && mem.cmd == `MIP_CMD_STORE && mem.addr[`MIP_A10];

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        case (st_q)
            mip_pkg::D_RESET: begin
                st_d  = mip_pkg::D_INIT;
                cnt_d = ld(INIT_WAIT_CYC);
            end
            mip_pkg::D_INIT: begin
                // Internal init runs on its own count, no clock needed
                if (cnt_done) st_d = mip_pkg::D_WAIT_CKE;
            end
            mip_pkg::D_WAIT_CKE: begin
                if (cke_seen_q) st_d = mip_pkg::D_CONFIG;
            end
            mip_pkg::D_CONFIG: begin
                if (is_zq) begin
                    st_d  = mip_pkg::D_CAL;
                    cnt_d = ld(`MIP_MAX(DLLK_CYC, ZQINIT_CYC));
                end
            end
            mip_pkg::D_CAL: begin
                if (cnt_done) st_d = mip_pkg::D_READY;
            end
            mip_pkg::D_READY: st_d = mip_pkg::D_READY;
            default:          st_d = mip_pkg::D_RESET;
        endcase
        if (!mem.reset_n) st_d = mip_pkg::D_RESET;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q       <= mip_pkg::D_RESET;
            cnt_q      <= '0;
            cke_seen_q <= 1'b0;
            ready_q    <= 1'b0;
            store_q    <= 1'b0;
            mr_data_q  <= 14'h0000;
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            // Termination stays high impedance until CKE registered high
            cke_seen_q <= mem.reset_n && (cke_seen_q || mem.cke);
            ready_q    <= (st_d == mip_pkg::D_READY);
            store_q    <= is_store && st_q == mip_pkg::D_READY;
            mr_data_q  <= (mr_sel_i == `MIP_MR_RCW) ? 14'h0000 : mr_q[mr_sel_i];
        end
    end

    for (genvar i = 0; i < 7; i++) begin : g_mr
        always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
                mr_q[i] <= 14'h0000;
            end else if (is_mrs && mr_sel == 3'(i)) begin
                // Only the mode register changes, no array state
                mr_q[i] <= mem.addr;
            end
        end
    end

    assign mr_data_o    = mr_data_q;
    assign ready_o      = ready_q;
    assign term_hiz_o   = !cke_seen_q;
    assign store_seen_o = store_q;
endmodule : mip_device

/* test/mip_props.sv */
`timescale 1ns/1ns
`include "mip_defines.svh"
module mip_props #(
    parameter int unsigned INIT_WAIT_CYC = 30
) (
    input wire logic                  clock_i,
    input wire logic                  rst_n_i,
    input wire logic                  reset_n,
    input wire logic                  ck_en,
    input wire logic                  cke,
    input wire logic                  cs_n,
    input wire logic [3:0]            cmd,
    input wire logic [1:0]            bg,
    input wire logic [1:0]            ba,
    input wire mip_pkg::mip_addr_type addr,
    input wire logic                  odt
);
    // Init order MR3,6,5,4,2,1,0, three bits a step
    localparam logic [23:0] MR_ORDER = 24'h00a973;
    logic [15:0] low_cnt;
    logic [15:0] hi_cnt;
    logic [7:0]  ck_cnt;
    logic [7:0]  cke_cnt;
    logic [7:0]  mod_cnt;
    logic [2:0]  seq_idx;
    wire         cmd_v = cke && !cs_n;
    wire         mrs_v = cmd_v && (cmd == `MIP_CMD_MRS);
    wire         zq_v  = cmd_v && (cmd == `MIP_CMD_ZQ);
    wire  [2:0]  tgt   = {bg[0], ba};
    wire  [2:0]  ord   = MR_ORDER[3*seq_idx +: 3];

    always_ff @(posedge clock_i) begin
        low_cnt <= (!rst_n_i || reset_n) ? 16'h0 : low_cnt + {15'h0, !(&low_cnt)};
        hi_cnt  <= !reset_n ? 16'h0 : hi_cnt + {15'h0, !(&hi_cnt)};
        ck_cnt  <= !ck_en ? 8'h0 : ck_cnt + {7'h0, !(&ck_cnt)};
        cke_cnt <= !cke ? 8'h0 : cke_cnt + {7'h0, !(&cke_cnt)};
    end
    always_ff @(posedge clock_i) begin
        mod_cnt <= !reset_n ? 8'hff : (mrs_v ? 8'h1 : mod_cnt + {7'h0, !(&mod_cnt)});
        seq_idx <= !reset_n ? 3'h0 : seq_idx + {2'h0, mrs_v && (seq_idx != 3'h7)};
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    rst_hold_a: assert property ($rose(reset_n) |-> low_cnt >= `MIP_RST_HOLD_CYC)
        else $error("reset pin released too early");
    cke_pre_a: assert property ($rose(reset_n) |-> !$past(cke, 1) && !$past(cke, 2) && !$past(cke, 3))
        else $error("cke not low before reset release");
    init_wait_a: assert property ($rose(cke) |-> hi_cnt >= INIT_WAIT_CYC)
        else $error("cke raised too soon after reset");
    clk_stab_a: assert property ($rose(cke) |-> cs_n && ck_cnt >= `MIP_CLK_STAB_CYC)
        else $error("clock not stable or no deselect at cke rise");
    cke_keep_a: assert property (cke && reset_n && seq_idx != 3'h7 |=> cke)
        else $error("cke dropped during init");
    odt_low_a: assert property (reset_n |-> !odt)
        else $error("odt not held low");
    xpr_a: assert property (mrs_v |-> cke_cnt >= `MIP_XPR_CYC)
        else $error("mode write too soon after cke");
    mr_order_a: assert property (mrs_v && seq_idx != 3'h7 |-> tgt == ord)
        else $error("mode register order wrong");
    mrd_gap_a: assert property (mrs_v |=> !cmd_v [*7])
        else $error("command inside mode write gap");
    mod_gap_a: assert property (cmd_v && cmd != `MIP_CMD_MRS |-> mod_cnt >= `MIP_MOD_CYC)
        else $error("command too soon after mode write");
    zq_long_a: assert property (zq_v |-> addr[`MIP_A10] && seq_idx == 3'h7)
        else $error("calibration not long or not after MR0");
    mr_dflt_a: assert property (mrs_v |-> !bg[1] && (tgt != 3'h1 || addr[0])
        && (tgt != 3'h3 || addr[4:3] == 2'h0) && (tgt != 3'h4 || (!addr[1] && addr[8:6] == 3'h0))
        && (tgt != 3'h5 || addr[2:0] == 3'h0))
        else $error("mode write default fields wrong");

    cke_up_c: cover property ($rose(cke));
    zq_c: cover property (zq_v);
    store_c: cover property (cmd_v && cmd == `MIP_CMD_STORE);
    update_c: cover property (mrs_v && seq_idx == 3'h7);
endmodule : mip_props

/* test/mram_init_and_mode_program_test.sv */
`timescale 1ns/1ns
module mram_init_and_mode_program_test;
    localparam logic [13:0] IMG = 14'h1a5a;
    logic        clock_i   = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [2:0]  mr_sel    = 3'h0;
    logic [31:0] reg_rdata;
    logic [13:0] mr_data;
    logic        ready;
    logic        term_hiz;
    logic        store_seen;
    logic [31:0] rd_val;
    int          errors      = 0;
    int          check_count = 0;

    mip_if mem_bus ();
    mip_ctrl #(.PWR_HOLD_CYC(40), .INIT_WAIT_CYC(30)) u_mip_ctrl (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .mem(mem_bus));
    mip_device #(.INIT_WAIT_CYC(30)) u_mip_device (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .mem(mem_bus), .mr_sel_i(mr_sel), .mr_data_o(mr_data),
        .ready_o(ready), .term_hiz_o(term_hiz), .store_seen_o(store_seen));
    mip_props u_mip_props (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reset_n(mem_bus.reset_n), .ck_en(mem_bus.ck_en),
        .cke(mem_bus.cke), .cs_n(mem_bus.cs_n), .cmd(mem_bus.cmd), .bg(mem_bus.bg), .ba(mem_bus.ba),
        .addr(mem_bus.addr), .odt(mem_bus.odt));

    always #2 clock_i = ~clock_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock_i);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock_i);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic mr_check(input logic [2:0] s, input logic [13:0] exp);
        @(posedge clock_i);
        mr_sel <= s;
        repeat (2) @(posedge clock_i);
        #1 check({18'h0, mr_data}, {18'h0, exp});
    endtask : mr_check

    function automatic logic probe(input int w);
        case (w)
            0: probe = ready;
            1: probe = mem_bus.cke;
            2: probe = store_seen;
            default: probe = !mem_bus.reset_n;
        endcase
    endfunction : probe

    task automatic wait_on(input int w, input int lim);
        int n;
        n = 0;
        while (probe(w) !== 1'b1 && n < lim) begin
            @(posedge clock_i);
            #1 n++;
        end
        check(32'(probe(w)), 32'h1);
    endtask : wait_on

    task automatic wait_status(input logic [31:0] m);
        int n;
        n = 0;
        rd_val = 32'h0;
        while ((rd_val & m) !== m && n < 200) begin
            reg_read(4'h1, rd_val);
            n++;
        end
        check(rd_val & m, m);
    endtask : wait_status

    function automatic logic [13:0] exp_mr(input int i, input logic [13:0] v);
        case (i)
            0: exp_mr = v | 14'h0100;
            1: exp_mr = v | 14'h0001;
            3: exp_mr = v & ~14'h0018;
            4: exp_mr = v & ~14'h01c2;
            5: exp_mr = v & ~14'h0007;
            default: exp_mr = v;
        endcase
    endfunction : exp_mr

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 7; i++) reg_write(4'(i + 2), {18'h0, IMG});
        check(32'(term_hiz), 32'h1);
        check(32'(mem_bus.reset_n), 32'h0);
        reg_read(4'h4, rd_val);
        check(rd_val, {18'h0, IMG});
        reg_read(4'h0, rd_val);
        check(rd_val, 32'h0);
        reg_write(4'hf, 32'hffffffff);
        reg_read(4'h9, rd_val);
        check(rd_val, 32'h0);
        wait_on(1, 400);
        check(32'(term_hiz), 32'h1);
        wait_on(0, 1500);
        check(32'(term_hiz), 32'h0);
        wait_status(32'h1);
        for (int i = 0; i < 7; i++) mr_check(3'(i), exp_mr(i, IMG));
        $display("init test done");
        reg_write(4'h8, 32'h00000123);
        reg_write(4'h0, 32'h00000064);
        wait_status(32'h1);
        mr_check(3'h6, 14'h0123);
        mr_check(3'h5, exp_mr(5, IMG));
        $display("update test done");
        reg_write(4'h0, 32'h00000002);
        wait_on(2, 200);
        wait_status(32'h2);
        reg_write(4'h1, 32'h00000002);
        reg_read(4'h1, rd_val);
        check(rd_val & 32'h2, 32'h0);
        $display("store test done");
        reg_write(4'h3, 32'h0);
        reg_write(4'h0, 32'h00000001);
        wait_on(3, 20);
        check(32'(mem_bus.cke), 32'h0);
        repeat (2) @(posedge clock_i);
        #1 check(32'(term_hiz), 32'h1);
        check(32'(ready), 32'h0);
        wait_on(0, 1500);
        mr_check(3'h1, 14'h0001);
        mr_check(3'h0, exp_mr(0, IMG));
        $display("warm reset test done");
        stop_test();
    end
endmodule : mram_init_and_mode_program_test
